// [rtl/pcid_defines.svh]
`ifndef PCID_DEFINES_SVH
`define PCID_DEFINES_SVH

// Configuration dword offsets
`define PCID_OFS_ID 8'h00
`define PCID_OFS_CMD 8'h04

// Bus command codes on the C/BE lines
`define PCID_CMD_CFG_READ 4'hA
`define PCID_CMD_CFG_WRITE 4'hB

// Command register bit positions
`define PCID_BIT_IOSPACE 0
`define PCID_BIT_MEMSPACE 1
`define PCID_BIT_MASTER 2
`define PCID_BIT_SPCYCLE 3
`define PCID_BIT_MWI 4
`define PCID_BIT_VGASNOOP 5
`define PCID_BIT_PERRESP 6
`define PCID_BIT_WAITSTEP 7
`define PCID_BIT_SERRESP 8
`define PCID_BIT_FASTB2B 9

// Writable bits and reset value
`define PCID_CMD_WR_MASK 16'h0157
`define PCID_CMD_RESET 16'h0000

// Timing: override window after reset release
`define PCID_CLK_PERIOD_NS 10
`define PCID_OVR_WINDOW_NS 1000
`define PCID_OVR_WINDOW_CYC (`PCID_OVR_WINDOW_NS / `PCID_CLK_PERIOD_NS)

`endif

// [rtl/pcid_pkg.sv]
package pcid_pkg;
	// Phase of the identification byte override
	typedef enum logic [1:0] {
		PCID_OVR_RESET,
		PCID_OVR_OPEN,
		PCID_OVR_LOCKED
	} pcid_ovr_state_t;

	typedef logic [15:0] pcid_word16_t;
endpackage

// [rtl/pcid_id_latch.sv]
`include "pcid_defines.svh"

module pcid_id_latch
	import pcid_pkg::*;
#(
	parameter logic [7:0] DEFAULT_HIGH = 8'h5A,
	parameter int WINDOW_CYC = `PCID_OVR_WINDOW_CYC
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic override_en,
	input wire logic [7:0] external_code_override,
	output logic [7:0] product_code_high_byte,
	output logic override_open
);
	pcid_ovr_state_t state;
	logic [15:0] win_cnt;
	wire logic win_done = (win_cnt >= 16'(WINDOW_CYC - 1));
	wire logic take_ext = override_en && (sys_rst || state != PCID_OVR_LOCKED);

	assign override_open = sys_rst || (state != PCID_OVR_LOCKED);

	// Byte follows the override while reset is held and for the window after
	always_ff @(posedge mclk) begin
		if (take_ext) begin
			product_code_high_byte <= external_code_override;
		end else if (sys_rst) begin
			product_code_high_byte <= DEFAULT_HIGH;
		end
	end

	// Window timer; locks the byte for good until the next reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= PCID_OVR_RESET;
			win_cnt <= 16'h0000;
		end else begin
			case (state)
				PCID_OVR_RESET: begin
					state <= PCID_OVR_OPEN;
				end
				PCID_OVR_OPEN: begin
					win_cnt <= win_cnt + 16'h0001;
					if (win_done) begin
						state <= PCID_OVR_LOCKED;
					end
				end
				default: begin
					state <= PCID_OVR_LOCKED;
				end
			endcase
		end
	end
endmodule // pcid_id_latch

// [rtl/pcid_cfg_regs.sv]
`include "pcid_defines.svh"

module pcid_cfg_regs
	import pcid_pkg::*;
#(
	// Arbitrary neutral identity values
	parameter logic [15:0] PRODUCT_CODE_DEFAULT = 16'h5A3C,
	parameter logic [15:0] VENDOR_CODE = 16'h1234,
	parameter int OVR_WINDOW_CYC = `PCID_OVR_WINDOW_CYC
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic cfg_valid,
	input wire logic cfg_idsel,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_cmd,
	input wire logic [3:0] cfg_be_n,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_accept,
	output logic cfg_rvalid,
	output logic [31:0] cfg_rdata,
	input wire logic dev_id_rd,
	output logic dev_id_rvalid,
	output logic [15:0] dev_id_rdata,
	input wire logic override_en,
	input wire logic [7:0] external_code_override,
	input wire logic tgt_addr_parity_err,
	input wire logic tgt_wr_data_parity_err,
	input wire logic mst_rd_data_parity_err,
	input wire logic special_cycle_phase,
	input wire logic detected_parity_error_flag,
	input wire logic data_parity_reported_flag,
	input wire logic intr_enable,
	output logic serr_n_o,
	output logic serr_oe,
	output logic perr_n_o,
	output logic perr_oe,
	output logic interrupt_request_out,
	output logic io_space_enable,
	output logic mem_space_enable,
	output logic bus_master_enable,
	output logic mwi_enable,
	output logic system_error_response_enable,
	output logic parity_error_response_enable
);
	// Byte enables (active low) to a 16-bit write mask
	function automatic logic [15:0] lane_mask(input logic [1:0] be_n);
		lane_mask = {{8{~be_n[1]}}, {8{~be_n[0]}}};
	endfunction

	pcid_word16_t cmd_reg;
	pcid_word16_t product_identification_word;
	pcid_word16_t next_cmd;
	logic [7:0] product_code_high_byte;
	logic [7:0] product_code_low_byte;
	logic override_open;
	logic serr_drive;
	logic perr_drive;

	// High byte may be replaced around reset; low byte fixed
	pcid_id_latch #(
		.DEFAULT_HIGH(PRODUCT_CODE_DEFAULT[15:8]),
		.WINDOW_CYC(OVR_WINDOW_CYC)
	) u_id_latch (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.override_en(override_en),
		.external_code_override(external_code_override),
		.product_code_high_byte(product_code_high_byte),
		.override_open(override_open)
	);

	// Four nibbles: first character lowest, fourth highest
	assign product_code_low_byte = PRODUCT_CODE_DEFAULT[7:0];
	assign product_identification_word = {product_code_high_byte, product_code_low_byte};

	// Access decode; anything else on the bus is simply not claimed
	wire logic cfg_is_rd = (cfg_cmd == `PCID_CMD_CFG_READ);
	wire logic cfg_is_wr = (cfg_cmd == `PCID_CMD_CFG_WRITE);
	wire logic cfg_hit = cfg_valid && cfg_idsel && (cfg_addr[1:0] == 2'b00);
	assign cfg_accept = cfg_hit && (cfg_is_rd || cfg_is_wr);
	wire logic sel_id = (cfg_addr[7:2] == 6'(`PCID_OFS_ID >> 2));
	wire logic sel_cmd = (cfg_addr[7:2] == 6'(`PCID_OFS_CMD >> 2));
	wire logic cmd_wr = cfg_accept && cfg_is_wr && sel_cmd;

	// Only writable bits take data; fixed-zero bits never store
	wire logic [15:0] wr_mask = lane_mask(cfg_be_n[1:0]) & `PCID_CMD_WR_MASK;
	assign next_cmd = (cmd_reg & ~wr_mask) | (cfg_wdata[15:0] & wr_mask);

	// Read mux; status half and unmapped words return zero
	wire logic [31:0] rd_word =
		sel_id ? {product_identification_word, VENDOR_CODE} :
		sel_cmd ? {16'h0000, cmd_reg} :
		32'h0000_0000;

	// Command register; reset clears every writable bit
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cmd_reg <= `PCID_CMD_RESET;
		end else if (cmd_wr) begin
			cmd_reg <= next_cmd;
		end
	end

	// Configuration read answer one cycle after acceptance
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cfg_rvalid <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
		end else begin
			cfg_rvalid <= cfg_accept && cfg_is_rd;
			cfg_rdata <= (cfg_accept && cfg_is_rd) ? rd_word : 32'h0000_0000;
		end
	end

	// Device-space copy; gated by space enables, not by sequencer halt
	wire logic dev_ok = cmd_reg[`PCID_BIT_IOSPACE] || cmd_reg[`PCID_BIT_MEMSPACE];
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dev_id_rvalid <= 1'b0;
			dev_id_rdata <= 16'h0000;
		end else begin
			dev_id_rvalid <= dev_id_rd && dev_ok;
			dev_id_rdata <= (dev_id_rd && dev_ok) ? product_identification_word : 16'h0000;
		end
	end

	// Enables to the rest of the device; all zero means disconnected
	assign io_space_enable = cmd_reg[`PCID_BIT_IOSPACE];
	assign mem_space_enable = cmd_reg[`PCID_BIT_MEMSPACE];
	assign bus_master_enable = cmd_reg[`PCID_BIT_MASTER];
	assign mwi_enable = cmd_reg[`PCID_BIT_MWI];
	assign system_error_response_enable = cmd_reg[`PCID_BIT_SERRESP];
	assign parity_error_response_enable = cmd_reg[`PCID_BIT_PERRESP];

	// Error reporting; master side has no address parity input at all
	wire logic serr_cause = tgt_addr_parity_err && system_error_response_enable
		&& parity_error_response_enable;
	wire logic perr_cause = parity_error_response_enable && !special_cycle_phase
		&& (tgt_wr_data_parity_err || mst_rd_data_parity_err);
	wire logic irq_cause = parity_error_response_enable && intr_enable
		&& (detected_parity_error_flag || data_parity_reported_flag);

	// Registered pin drive; open-drain pulls low only while enabled
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			serr_drive <= 1'b0;
			perr_drive <= 1'b0;
			interrupt_request_out <= 1'b0;
		end else begin
			serr_drive <= serr_cause;
			perr_drive <= perr_cause;
			interrupt_request_out <= irq_cause;
		end
	end

	assign serr_oe = serr_drive;
	assign serr_n_o = ~serr_drive;
	assign perr_oe = perr_drive;
	assign perr_n_o = ~perr_drive;

	// Checks
	property p_id_cfg_read;
		@(posedge mclk) disable iff (sys_rst)
		cfg_accept && cfg_is_rd && sel_id |=>
			cfg_rvalid && (cfg_rdata[31:16] == $past(product_identification_word));
	endproperty
	a_id_cfg_read: assert property (p_id_cfg_read) else $error("id config read wrong");

	property p_dev_read_gate;
		@(posedge mclk) disable iff (sys_rst)
		dev_id_rd |=> (dev_id_rvalid == $past(dev_ok))
			&& (!dev_id_rvalid || dev_id_rdata == $past(product_identification_word));
	endproperty
	a_dev_read_gate: assert property (p_dev_read_gate) else $error("device id read gating");

	property p_id_locked;
		@(posedge mclk) disable iff (sys_rst)
		!override_open |=> $stable(product_identification_word);
	endproperty
	a_id_locked: assert property (p_id_locked) else $error("id changed after window");

	property p_low_byte_fixed;
		@(posedge mclk) disable iff (sys_rst)
		product_identification_word[7:0] == PRODUCT_CODE_DEFAULT[7:0];
	endproperty
	a_low_byte_fixed: assert property (p_low_byte_fixed) else $error("low id byte moved");

	property p_disconnect;
		@(posedge mclk) disable iff (sys_rst)
		cmd_wr && (cfg_be_n[1:0] == 2'b00) && (cfg_wdata[15:0] == 16'h0000) |=>
			!io_space_enable && !mem_space_enable && !bus_master_enable && !mwi_enable;
	endproperty
	a_disconnect: assert property (p_disconnect) else $error("zero write left enables");

	property p_cmd_read;
		@(posedge mclk) disable iff (sys_rst)
		cfg_accept && cfg_is_rd && sel_cmd |=>
			cfg_rvalid && (cfg_rdata == {16'h0000, $past(cmd_reg)});
	endproperty
	a_cmd_read: assert property (p_cmd_read) else $error("command read wrong");

	property p_zero_bits;
		@(posedge mclk) disable iff (sys_rst)
		(cmd_reg & ~`PCID_CMD_WR_MASK) == 16'h0000;
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("fixed-zero bit set");

	property p_serr;
		@(posedge mclk) disable iff (sys_rst)
		##1 serr_oe == $past(tgt_addr_parity_err && system_error_response_enable
			&& parity_error_response_enable);
	endproperty
	a_serr: assert property (p_serr) else $error("system error drive mismatch");

	property p_perr;
		@(posedge mclk) disable iff (sys_rst)
		parity_error_response_enable && !special_cycle_phase
			&& (tgt_wr_data_parity_err || mst_rd_data_parity_err)
			|=> perr_oe && !perr_n_o;
	endproperty
	a_perr: assert property (p_perr) else $error("parity error not driven");

	property p_perr_quiet;
		@(posedge mclk) disable iff (sys_rst)
		!parity_error_response_enable || special_cycle_phase |=> !perr_oe;
	endproperty
	a_perr_quiet: assert property (p_perr_quiet) else $error("parity error driven");

	property p_irq;
		@(posedge mclk) disable iff (sys_rst)
		interrupt_request_out |-> $past(parity_error_response_enable && intr_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without enables");

	property p_reset_clear;
		@(posedge mclk)
		sys_rst |=> !system_error_response_enable && !parity_error_response_enable
			&& !serr_oe && !perr_oe && (cmd_reg == `PCID_CMD_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left bits set");

	property p_unclaimed;
		@(posedge mclk) disable iff (sys_rst)
		cfg_valid && !cfg_accept |=> $stable(cmd_reg) && !cfg_rvalid;
	endproperty
	a_unclaimed: assert property (p_unclaimed) else $error("unclaimed access acted");

	property p_id_write_ignored;
		@(posedge mclk) disable iff (sys_rst)
		cfg_accept && cfg_is_wr && !sel_cmd |=> $stable(cmd_reg) && !cfg_rvalid;
	endproperty
	a_id_write_ignored: assert property (p_id_write_ignored) else $error("id write acted");

	property p_rdata_idle;
		@(posedge mclk) disable iff (sys_rst)
		!cfg_rvalid |->
			cfg_rdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

	property p_dev_rdata_idle;
		@(posedge mclk) disable iff (sys_rst)
		!dev_id_rvalid |->
			dev_id_rdata == 16'h0000;
	endproperty
	a_dev_rdata_idle: assert property (p_dev_rdata_idle) else $error("device data not cleared");

	property p_serr_source;
		@(posedge mclk) disable iff (sys_rst)
		!tgt_addr_parity_err |=>
			!serr_oe && serr_n_o;
	endproperty
	a_serr_source: assert property (p_serr_source) else $error("system error without cause");

	property p_pin_levels;
		@(posedge mclk) disable iff (sys_rst)
		(serr_n_o == !serr_oe)
			&& (perr_n_o == !perr_oe);
	endproperty
	a_pin_levels: assert property (p_pin_levels) else $error("pin level and enable differ");

	property p_cmd_wr_full;
		@(posedge mclk) disable iff (sys_rst)
		cmd_wr && (cfg_be_n[1:0] == 2'b00) |=>
			cmd_reg == ($past(cfg_wdata[15:0]) & `PCID_CMD_WR_MASK);
	endproperty
	a_cmd_wr_full: assert property (p_cmd_wr_full) else $error("command write wrong");

	property p_irq_raise;
		@(posedge mclk) disable iff (sys_rst)
		parity_error_response_enable && intr_enable
			&& (detected_parity_error_flag || data_parity_reported_flag)
			|=> interrupt_request_out;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

	property p_accept_decode;
		@(posedge mclk) disable iff (sys_rst)
		cfg_accept |->
			cfg_valid && cfg_idsel && (cfg_addr[1:0] == 2'b00);
	endproperty
	a_accept_decode: assert property (p_accept_decode) else $error("access claimed wrongly");

	property p_dev_refused;
		@(posedge mclk) disable iff (sys_rst)
		dev_id_rd && !io_space_enable && !mem_space_enable |=>
			!dev_id_rvalid;
	endproperty
	a_dev_refused: assert property (p_dev_refused) else $error("device read while disabled");
endmodule // pcid_cfg_regs

// [dv/pcid_host_model.sv]
module pcid_host_model (
	input wire logic mclk,
	input wire logic cfg_accept,
	input wire logic cfg_rvalid,
	input wire logic [31:0] cfg_rdata,
	output logic cfg_valid,
	output logic cfg_idsel,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_cmd,
	output logic [3:0] cfg_be_n,
	output logic [31:0] cfg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero
	initial begin
		cfg_valid = 1'b0;
		cfg_idsel = 1'b0;
		cfg_addr = 8'h00;
		cfg_cmd = 4'h0;
		cfg_be_n = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end

	// One data phase, held until the taking edge, answer read one cycle later
	task automatic access(input logic sel, input logic [7:0] a, input logic [3:0] c,
		input logic [31:0] wd, output logic acc, output logic rv, output logic [31:0] rd);
		@(negedge mclk);
		cfg_valid = 1'b1;
		cfg_idsel = sel;
		cfg_addr = a;
		cfg_cmd = c;
		cfg_wdata = wd;
		#1 acc = cfg_accept;
		@(negedge mclk);
		rv = cfg_rvalid;
		rd = cfg_rdata;
		cfg_valid = 1'b0;
		cfg_idsel = 1'b0;
		// Released lines flip so a stale value is never mistaken for data
		cfg_addr = ~cfg_addr;
		cfg_wdata = ~cfg_wdata;
	endtask

	// Byte lanes for the following accesses; changed off the sampling edge
	task automatic set_lanes(input logic [3:0] be_n);
		@(negedge mclk);
		cfg_be_n = be_n;
	endtask
endmodule // pcid_host_model

// [dv/pcid_cfg_regs_tb.sv]
module pcid_cfg_regs_tb;
	import pcid_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] PID = 16'h5A3C; // Arbitrary product code
	localparam logic [15:0] VID = 16'h1234; // Arbitrary vendor code
	logic mclk, sys_rst, cfg_valid, cfg_idsel, cfg_accept, cfg_rvalid, dev_id_rd, dev_id_rvalid;
	logic [7:0] cfg_addr, external_code_override;
	logic [3:0] cfg_cmd, cfg_be_n, errs;
	logic [31:0] cfg_wdata, cfg_rdata, rd;
	logic [15:0] dev_id_rdata;
	logic override_en, flag_det, flag_rep, intr_enable, serr_n_o, serr_oe, perr_n_o, perr_oe;
	logic irq, io_en, mem_en, bm_en, mwi_en, se_en, pe_en, acc, rv;
	logic [1:0] seen;
	int fails, comparisons, cycles;

	pcid_cfg_regs #(.PRODUCT_CODE_DEFAULT(PID), .VENDOR_CODE(VID), .OVR_WINDOW_CYC(4)) dut_u (
		.mclk(mclk), .sys_rst(sys_rst), .cfg_valid(cfg_valid), .cfg_idsel(cfg_idsel),
		.cfg_addr(cfg_addr), .cfg_cmd(cfg_cmd), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata),
		.cfg_accept(cfg_accept), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata),
		.dev_id_rd(dev_id_rd), .dev_id_rvalid(dev_id_rvalid), .dev_id_rdata(dev_id_rdata),
		.override_en(override_en), .external_code_override(external_code_override),
		.tgt_addr_parity_err(errs[3]), .tgt_wr_data_parity_err(errs[2]),
		.mst_rd_data_parity_err(errs[1]), .special_cycle_phase(errs[0]),
		.detected_parity_error_flag(flag_det), .data_parity_reported_flag(flag_rep),
		.intr_enable(intr_enable), .serr_n_o(serr_n_o), .serr_oe(serr_oe),
		.perr_n_o(perr_n_o), .perr_oe(perr_oe), .interrupt_request_out(irq),
		.io_space_enable(io_en), .mem_space_enable(mem_en), .bus_master_enable(bm_en),
		.mwi_enable(mwi_en), .system_error_response_enable(se_en),
		.parity_error_response_enable(pe_en));

	pcid_host_model host_u (.mclk(mclk), .cfg_accept(cfg_accept), .cfg_rvalid(cfg_rvalid),
		.cfg_rdata(cfg_rdata), .cfg_valid(cfg_valid), .cfg_idsel(cfg_idsel), .cfg_addr(cfg_addr),
		.cfg_cmd(cfg_cmd), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Cut a hang short; the whole run needs well under two hundred cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			$display("wrong value at %0t: timeout", $time);
			summarize();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic rd_reg(input logic [7:0] a);
		host_u.access(1'b1, a, 4'hA, 32'h0000_0000, acc, rv, rd);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		host_u.access(1'b1, a, 4'hB, d, acc, rv, rd);
	endtask

	task automatic do_reset(input logic ovr, input logic [7:0] code);
		@(negedge mclk);
		sys_rst = 1'b1;
		override_en = ovr;
		external_code_override = code;
		repeat (5) @(negedge mclk);
		sys_rst = 1'b0;
	endtask

	// Device-space read; answer only with io or memory space enabled
	task automatic dev_read(input logic en);
		@(negedge mclk);
		dev_id_rd = 1'b1;
		@(negedge mclk);
		dev_id_rd = 1'b0;
		check({dev_id_rvalid, dev_id_rdata}, {en, en ? PID : 16'h0000}, "device read");
	endtask

	// Error pulse, then the pins watched for two cycles
	task automatic pulse(input logic [3:0] e, input logic [1:0] exp);
		@(negedge mclk);
		errs = e;
		seen = 2'b00;
		@(negedge mclk);
		errs = 4'h0;
		seen = seen | {serr_oe, perr_oe};
		check({serr_n_o, perr_n_o}, {!serr_oe, !perr_oe}, "pin levels");
		@(negedge mclk);
		seen = seen | {serr_oe, perr_oe};
		check(seen, exp, "error pins");
	endtask

	task automatic t_reset_values();
		do_reset(1'b0, 8'h00);
		rd_reg(8'h04);
		check(rv, 1'b1, "read answered");
		check(rd, 32'h0000_0000, "command after reset");
		check({io_en, mem_en, bm_en, mwi_en, se_en, pe_en}, 6'h00, "enables");
		rd_reg(8'h00);
		check(rd, {PID, VID}, "id word");
		rd_reg(8'h08);
		check(rd, 32'h0000_0000, "unmapped word");
	endtask

	task automatic t_cmd_mask();
		wr_reg(8'h04, 32'hFFFF_FFFF);
		check(acc, 1'b1, "write accept");
		rd_reg(8'h04);
		check(rd, 32'h0000_0157, "constant-zero bits");
		check({io_en, mem_en, bm_en, mwi_en, se_en, pe_en}, 6'h3F, "enables");
		host_u.set_lanes(4'h1);
		wr_reg(8'h04, 32'h0000_0000);
		rd_reg(8'h04);
		check(rd, 32'h0000_0057, "upper lane only");
		host_u.set_lanes(4'h2);
		wr_reg(8'h04, 32'h0000_FF00);
		rd_reg(8'h04);
		check(rd, 32'h0000_0000, "lower lane only");
		host_u.set_lanes(4'h0);
		wr_reg(8'h00, 32'h0000_0000);
		rd_reg(8'h00);
		check(rd, {PID, VID}, "id after write");
	endtask

	task automatic t_disconnect();
		logic [31:0] cmds [4] = '{32'h0, 32'h1, 32'h2, 32'h14};
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'h04, cmds[i]);
			dev_read(i == 1 || i == 2);
		end
	endtask

	task automatic t_refuse();
		logic sel [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		logic [7:0] ad [4] = '{8'h04, 8'h05, 8'h04, 8'h04};
		logic [3:0] cm [4] = '{4'hB, 4'hB, 4'h7, 4'hA};
		wr_reg(8'h04, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			host_u.access(sel[i], ad[i], cm[i], 32'hFFFF_FFFF, acc, rv, rd);
			check({acc, rv}, 2'b00, "refused access");
		end
		rd_reg(8'h04);
		check(rd, 32'h0000_0000, "command unchanged");
	endtask

	task automatic t_errors();
		wr_reg(8'h04, 32'h0000_0040);
		pulse(4'h8, 2'b00);
		pulse(4'h2, 2'b01);
		pulse(4'h5, 2'b00);
		wr_reg(8'h04, 32'h0000_0140);
		pulse(4'h8, 2'b10);
		pulse(4'h4, 2'b01);
		pulse(4'h2, 2'b01);
		flag_det = 1'b1;
		intr_enable = 1'b1;
		repeat (2) @(negedge mclk);
		check(irq, 1'b1, "interrupt on");
		intr_enable = 1'b0;
		repeat (2) @(negedge mclk);
		check(irq, 1'b0, "interrupt masked");
		intr_enable = 1'b1;
		wr_reg(8'h04, 32'h0000_0100);
		pulse(4'h8, 2'b00);
		pulse(4'h2, 2'b00);
		check(irq, 1'b0, "interrupt gated");
		flag_det = 1'b0;
		flag_rep = 1'b1;
		wr_reg(8'h04, 32'h0000_0040);
		repeat (2) @(negedge mclk);
		check(irq, 1'b1, "reported flag");
		flag_rep = 1'b0;
	endtask

	task automatic t_override();
		wr_reg(8'h04, 32'h0000_0157);
		do_reset(1'b1, 8'hC3);
		rd_reg(8'h00);
		check(rd, {8'hC3, PID[7:0], VID}, "override at reset");
		// Still inside the window: a new byte must be taken
		external_code_override = 8'h69;
		rd_reg(8'h04);
		check(rd, 32'h0000_0000, "command reset");
		repeat (10) @(negedge mclk);
		external_code_override = 8'h96;
		rd_reg(8'h00);
		check(rd, {8'h69, PID[7:0], VID}, "override in window");
		override_en = 1'b0;
		rd_reg(8'h00);
		check(rd, {8'h69, PID[7:0], VID}, "override frozen");
		do_reset(1'b0, 8'h96);
		rd_reg(8'h00);
		check(rd, {PID, VID}, "default again");
	endtask

	task automatic summarize();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		sys_rst = 1'b1;
		dev_id_rd = 1'b0;
		override_en = 1'b0;
		external_code_override = 8'h00;
		errs = 4'h0;
		flag_det = 1'b0;
		flag_rep = 1'b0;
		intr_enable = 1'b0;
		t_reset_values();
		t_cmd_mask();
		t_disconnect();
		t_refuse();
		t_errors();
		t_override();
		summarize();
	end
endmodule // pcid_cfg_regs_tb
